// ### verilog/rsp_pkg.sv
// Shared constants and types of the serial slave port
package rsp_pkg;
    // Fixed 7-bit slave address, the byte D0h without its direction bit
    localparam logic [6:0] SLAVE_ADDR = 7'h68;
    localparam logic [7:0] PTR_RESET = 8'h00;
    // Last of the 20 byte locations
    localparam logic [7:0] PTR_LAST = 8'h13;
    // Last clock location; 00h..07h hold the running time
    localparam logic [7:0] CLOCK_LAST = 8'h07;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} rsp_link_e;
    typedef enum logic [1:0] {K_SLAVE, K_WORD, K_DATA} rsp_kind_e;
endpackage : rsp_pkg

// ### verilog/rsp_afifo.sv
// Dual-clock FIFO with gray-coded pointers
`timescale 1ns/1ps
module rsp_afifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = rsp_pkg::FIFO_DEPTH
) (
    input wire logic wr_clk,
    input wire logic wr_rst,
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    output logic wr_ready,
    input wire logic rd_clk,
    input wire logic rd_rst,
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] far_s1;
        logic [AW:0] far_s2;
    } rsp_side_s;

    function automatic logic [AW:0] rsp_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : rsp_gray

    logic [WIDTH-1:0] mem [DEPTH];
    rsp_side_s w_r;
    rsp_side_s w_nxt;
    rsp_side_s r_r;
    rsp_side_s r_nxt;

    // Full when the far pointer is one lap behind
    assign wr_ready = (w_r.gray != {~w_r.far_s2[AW:AW-1], w_r.far_s2[AW-2:0]}) ? 1'b1 : 1'b0;
    assign rd_valid = (r_r.gray != r_r.far_s2);
    assign rd_data = mem[r_r.bin[AW-1:0]];

    always_comb begin
        w_nxt = w_r;
        w_nxt.far_s1 = r_r.gray;
        w_nxt.far_s2 = w_r.far_s1;
        if (wr_valid && wr_ready) begin
            w_nxt.bin = w_r.bin + 1'b1;
            w_nxt.gray = rsp_gray(w_nxt.bin);
        end
    end

    always_comb begin
        r_nxt = r_r;
        r_nxt.far_s1 = w_r.gray;
        r_nxt.far_s2 = r_r.far_s1;
        if (rd_valid && rd_ready) begin
            r_nxt.bin = r_r.bin + 1'b1;
            r_nxt.gray = rsp_gray(r_nxt.bin);
        end
    end

    always_ff @(posedge wr_clk) begin
        if (wr_rst) begin
            w_r <= '0;
        end else begin
            w_r <= w_nxt;
        end
    end

    always_ff @(posedge wr_clk) begin
        if (!wr_rst && wr_valid && wr_ready) begin
            mem[w_r.bin[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge rd_clk) begin
        if (rd_rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end
endmodule : rsp_afifo

// ### verilog/rsp_slave_port.sv
// Two-wire serial slave port giving a master access to 20 byte registers
`timescale 1ns/1ps
module rsp_slave_port (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic below_battery_switchover_level,
    output logic reg_wr,
    output logic [rsp_pkg::ADDR_W-1:0] reg_wr_addr,
    output logic [rsp_pkg::DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr_ready,
    output logic reg_rd,
    output logic [rsp_pkg::ADDR_W-1:0] reg_rd_addr,
    input wire logic [rsp_pkg::DATA_W-1:0] reg_rdata,
    output logic clock_freeze
);
    localparam int WORD_W = rsp_pkg::ADDR_W + rsp_pkg::DATA_W;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_q;
        logic sda_s1;
        logic sda_s2;
        logic sda_q;
        logic pf_s1;
        logic pf_s2;
        rsp_pkg::rsp_link_e state;
        rsp_pkg::rsp_kind_e kind;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic rw;
        logic mack;
        logic [7:0] ptr;
        logic in_xfer;
        logic frz;
        logic sda_oe;
        logic sda_out;
        logic rd_req_tgl;
        logic [7:0] rd_addr;
        logic ack_s1;
        logic ack_s2;
        logic push_pend;
        logic [WORD_W-1:0] push_word;
    } rsp_link_s;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic ack_tgl;
        logic rd_busy;
        logic [7:0] rdata;
        logic frz_s1;
        logic frz_s2;
        logic freeze;
        logic reg_rd;
        logic [7:0] reg_rd_addr;
        logic reg_wr;
        logic [7:0] reg_wr_addr;
        logic [7:0] reg_wr_data;
    } rsp_sys_s;

    function automatic logic [7:0] rsp_ptr_next(input logic [7:0] p);
        return (p == rsp_pkg::PTR_LAST) ? rsp_pkg::PTR_RESET : p + 8'h01;
    endfunction : rsp_ptr_next

    rsp_link_s l_r;
    rsp_link_s l_nxt;
    rsp_sys_s s_r;
    rsp_sys_s s_nxt;
    logic [rsp_pkg::SYNC_STAGES-1:0] lrst_sync_r;
    logic link_rst;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    logic [WORD_W-1:0] fifo_rd_data;

    // Reset carried into the link domain
    always_ff @(posedge link_clk) begin
        lrst_sync_r <= {lrst_sync_r[0], srst};
    end
    assign link_rst = lrst_sync_r[rsp_pkg::SYNC_STAGES-1];

    assign scl_rise = l_r.scl_s2 && !l_r.scl_q;
    assign scl_fall = !l_r.scl_s2 && l_r.scl_q;
    assign bus_start = l_r.scl_s2 && l_r.scl_q && l_r.sda_q && !l_r.sda_s2;
    assign bus_stop = l_r.scl_s2 && l_r.scl_q && !l_r.sda_q && l_r.sda_s2;
    rsp_afifo #(
        .WIDTH(WORD_W),
        .DEPTH(rsp_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .wr_clk(link_clk),
        .wr_rst(link_rst),
        .wr_valid(l_r.push_pend),
        .wr_data(l_r.push_word),
        .wr_ready(fifo_wr_ready),
        .rd_clk(sys_clk),
        .rd_rst(srst),
        .rd_valid(fifo_rd_valid),
        .rd_data(fifo_rd_data),
        .rd_ready(reg_wr_ready)
    );

    always_comb begin
        l_nxt = l_r;
        l_nxt.scl_s1 = scl_in;
        l_nxt.scl_s2 = l_r.scl_s1;
        l_nxt.scl_q = l_r.scl_s2;
        l_nxt.sda_s1 = sda_in;
        l_nxt.sda_s2 = l_r.sda_s1;
        l_nxt.sda_q = l_r.sda_s2;
        l_nxt.pf_s1 = below_battery_switchover_level;
        l_nxt.pf_s2 = l_r.pf_s1;
        l_nxt.ack_s1 = s_r.ack_tgl;
        l_nxt.ack_s2 = l_r.ack_s1;
        l_nxt.sda_out = 1'b0;
        if (l_r.push_pend && fifo_wr_ready) begin
            l_nxt.push_pend = 1'b0;
        end
        if (l_r.pf_s2) begin
            // Abort, clear pointer, ignore the bus
            l_nxt.state = rsp_pkg::ST_IDLE;
            l_nxt.ptr = rsp_pkg::PTR_RESET;
            l_nxt.sda_oe = 1'b0;
            l_nxt.in_xfer = 1'b0;
            l_nxt.push_pend = 1'b0;
        end else if (bus_start) begin
            // Also a repeated START inside a transfer
            l_nxt.state = rsp_pkg::ST_RX;
            l_nxt.kind = rsp_pkg::K_SLAVE;
            l_nxt.cnt = rsp_pkg::CNT_RESET;
            l_nxt.sda_oe = 1'b0;
            l_nxt.in_xfer = 1'b1;
        end else if (bus_stop) begin
            l_nxt.state = rsp_pkg::ST_IDLE;
            l_nxt.sda_oe = 1'b0;
            l_nxt.in_xfer = 1'b0;
        end else begin
            unique case (l_r.state)
                rsp_pkg::ST_IDLE: begin
                    l_nxt.sda_oe = 1'b0;
                end
                rsp_pkg::ST_RX: begin
                    if (scl_rise && l_r.cnt != rsp_pkg::BYTE_BITS) begin
                        l_nxt.shreg = {l_r.shreg[6:0], l_r.sda_s2};
                        l_nxt.cnt = l_r.cnt + 4'h1;
                    end else if (scl_fall && l_r.cnt == rsp_pkg::BYTE_BITS) begin
                        if (l_r.kind == rsp_pkg::K_SLAVE
                                && l_r.shreg[7:1] != rsp_pkg::SLAVE_ADDR) begin
                            l_nxt.state = rsp_pkg::ST_IDLE;
                            l_nxt.in_xfer = 1'b0;
                        end else begin
                            l_nxt.state = rsp_pkg::ST_RX_ACK;
                            l_nxt.sda_oe = 1'b1;
                        end
                    end
                end
                rsp_pkg::ST_RX_ACK: begin
                    if (scl_rise) begin
                        unique case (l_r.kind)
                            rsp_pkg::K_SLAVE: l_nxt.rw = l_r.shreg[0];
                            rsp_pkg::K_WORD: l_nxt.ptr = l_r.shreg;
                            rsp_pkg::K_DATA: begin
                                l_nxt.push_pend = 1'b1;
                                l_nxt.push_word = {l_r.ptr, l_r.shreg};
                                l_nxt.ptr = rsp_ptr_next(l_r.ptr);
                            end
                            default: l_nxt.kind = rsp_pkg::K_DATA;
                        endcase
                    end else if (scl_fall) begin
                        l_nxt.sda_oe = 1'b0;
                        l_nxt.cnt = rsp_pkg::CNT_RESET;
                        if (l_r.kind == rsp_pkg::K_SLAVE && l_r.rw) begin
                            l_nxt.state = rsp_pkg::ST_TX;
                            l_nxt.rd_req_tgl = ~l_r.rd_req_tgl;
                            l_nxt.rd_addr = l_r.ptr;
                        end else begin
                            l_nxt.state = rsp_pkg::ST_RX;
                            l_nxt.kind = (l_r.kind == rsp_pkg::K_SLAVE) ? rsp_pkg::K_WORD
                                                                        : rsp_pkg::K_DATA;
                        end
                    end
                end
                rsp_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (l_r.cnt == rsp_pkg::BYTE_BITS - 4'h1) begin
                            l_nxt.state = rsp_pkg::ST_TX_ACK;
                            l_nxt.sda_oe = 1'b0;
                        end else begin
                            l_nxt.cnt = l_r.cnt + 4'h1;
                        end
                    end
                end
                rsp_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        l_nxt.mack = !l_r.sda_s2;
                        l_nxt.ptr = rsp_ptr_next(l_r.ptr);
                    end else if (scl_fall) begin
                        if (l_r.mack) begin
                            l_nxt.state = rsp_pkg::ST_TX;
                            l_nxt.cnt = rsp_pkg::CNT_RESET;
                            l_nxt.rd_req_tgl = ~l_r.rd_req_tgl;
                            l_nxt.rd_addr = l_r.ptr;
                        end else begin
                            l_nxt.state = rsp_pkg::ST_IDLE;
                        end
                    end
                end
                default: l_nxt.state = rsp_pkg::ST_IDLE;
            endcase
        end
        // Bits change only while the clock is low, MSB first
        if (l_nxt.state == rsp_pkg::ST_TX && !l_r.scl_s2) begin
            // Released until the fetched byte is back from the system side
            l_nxt.sda_oe = (l_r.ack_s2 == l_nxt.rd_req_tgl)
                && !s_r.rdata[~l_nxt.cnt[2:0]];
        end
        l_nxt.frz = l_nxt.in_xfer && (l_nxt.ptr <= rsp_pkg::CLOCK_LAST);
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.req_s1 = l_r.rd_req_tgl;
        s_nxt.req_s2 = s_r.req_s1;
        s_nxt.frz_s1 = l_r.frz;
        s_nxt.frz_s2 = s_r.frz_s1;
        s_nxt.freeze = s_r.frz_s2;
        s_nxt.reg_rd = 1'b0;
        if (s_r.rd_busy) begin
            // Data stands one cycle after the strobe
            if (!s_r.reg_rd) begin
                s_nxt.rdata = reg_rdata;
                s_nxt.ack_tgl = ~s_r.ack_tgl;
                s_nxt.rd_busy = 1'b0;
            end
        end else if (s_r.req_s2 != s_r.ack_tgl) begin
            // Address held stable by the link until acknowledged
            s_nxt.reg_rd = 1'b1;
            s_nxt.reg_rd_addr = l_r.rd_addr;
            s_nxt.rd_busy = 1'b1;
        end
        s_nxt.reg_wr = fifo_rd_valid && reg_wr_ready;
        if (fifo_rd_valid && reg_wr_ready) begin
            s_nxt.reg_wr_addr = fifo_rd_data[WORD_W-1:rsp_pkg::DATA_W];
            s_nxt.reg_wr_data = fifo_rd_data[rsp_pkg::DATA_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sda_out = l_r.sda_out;
    assign sda_oe = l_r.sda_oe;
    assign reg_wr = s_r.reg_wr;
    assign reg_wr_addr = s_r.reg_wr_addr;
    assign reg_wr_data = s_r.reg_wr_data;
    assign reg_rd = s_r.reg_rd;
    assign reg_rd_addr = s_r.reg_rd_addr;
    assign clock_freeze = s_r.freeze;

    a_pf_abort: assert property (@(posedge link_clk) disable iff (link_rst)
        l_r.pf_s2 |=> (l_r.state == rsp_pkg::ST_IDLE) && (l_r.ptr == rsp_pkg::PTR_RESET))
        else $error("power fail did not abort and clear pointer");
    a_pf_quiet: assert property (@(posedge link_clk) disable iff (link_rst)
        l_r.pf_s2 |=> !l_r.sda_oe && !l_r.push_pend && !l_r.in_xfer)
        else $error("bus still active during power fail");
    a_start_seen: assert property (@(posedge link_clk) disable iff (link_rst)
        bus_start && !l_r.pf_s2 |=> l_r.state == rsp_pkg::ST_RX && l_r.cnt == 4'h0)
        else $error("start not taken");
    a_stop_seen: assert property (@(posedge link_clk) disable iff (link_rst)
        bus_stop && !l_r.pf_s2 |=> l_r.state == rsp_pkg::ST_IDLE && !l_r.in_xfer)
        else $error("stop not taken");
    a_addr_match: assert property (@(posedge link_clk) disable iff (link_rst)
        $rose(l_r.state == rsp_pkg::ST_RX_ACK) && l_r.kind == rsp_pkg::K_SLAVE
        |-> l_r.shreg[7:1] == rsp_pkg::SLAVE_ADDR)
        else $error("acknowledged a foreign address");
    a_ack_stable: assert property (@(posedge link_clk) disable iff (link_rst)
        l_r.state == rsp_pkg::ST_RX_ACK && l_r.scl_s2 |-> l_r.sda_oe)
        else $error("acknowledge not held over clock high");
    a_nack_release: assert property (@(posedge link_clk) disable iff (link_rst)
        l_r.state == rsp_pkg::ST_TX_ACK |-> !l_r.sda_oe)
        else $error("line held during master acknowledge");
    a_drive_owner: assert property (@(posedge link_clk) disable iff (link_rst)
        l_r.sda_oe |-> !l_r.sda_out && (l_r.state inside {rsp_pkg::ST_RX_ACK, rsp_pkg::ST_TX}))
        else $error("line driven outside acknowledge or transmit");
    a_ptr_step: assert property (@(posedge link_clk) disable iff (link_rst)
        !$stable(l_r.ptr) |-> $past(l_r.pf_s2) || ($past(scl_rise)
        && $past(l_r.state) inside {rsp_pkg::ST_RX_ACK, rsp_pkg::ST_TX_ACK}))
        else $error("pointer moved outside an acknowledge clock");
    a_bit_count: assert property (@(posedge link_clk) disable iff (link_rst)
        scl_rise && l_r.state == rsp_pkg::ST_RX && l_r.cnt < 4'h8 && !bus_start
        && !bus_stop && !l_r.pf_s2 |=> l_r.cnt == $past(l_r.cnt) + 4'h1)
        else $error("receive bit count did not advance");
    a_freeze_sync: assert property (@(posedge sys_clk) disable iff (srst)
        s_r.frz_s2 |=> clock_freeze)
        else $error("clock freeze not forwarded");
    a_read_cycle: assert property (@(posedge sys_clk) disable iff (srst)
        reg_rd |-> s_r.rd_busy ##1 s_r.rd_busy && !reg_rd ##1 !s_r.rd_busy)
        else $error("read strobe not answered in two cycles");

    c_write_byte: cover property (@(posedge link_clk) disable iff (link_rst)
        $rose(l_r.push_pend));
    c_read_acked: cover property (@(posedge link_clk) disable iff (link_rst)
        l_r.state == rsp_pkg::ST_TX_ACK && scl_fall && l_r.mack);
    c_pf_in_xfer: cover property (@(posedge link_clk) disable iff (link_rst)
        l_r.in_xfer && l_r.pf_s2);
    c_freeze: cover property (@(posedge sys_clk) disable iff (srst) $rose(clock_freeze));
endmodule : rsp_slave_port

// ### verification/rsp_bus_master.sv
// Behavioural two-wire bus master for the serial slave port
`timescale 1ns/1ps
module rsp_bus_master (
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // Idle bus: clock and data both released high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Data moves only in the low phase, sampled in the middle of the high phase
    task automatic put_bit(input logic b, output logic s);
        #400 sda_low = ~b;
        #1000 scl = 1'b1;
        #320 s = sda;
        #320 scl = 1'b0;
    endtask : put_bit

    // Plain or repeated start
    task automatic start_cond();
        if (scl === 1'b0) begin
            #400 sda_low = 1'b0;
            #1000 scl = 1'b1;
            #640;
        end
        sda_low = 1'b1;
        #640 scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #400 sda_low = 1'b1;
        #1000 scl = 1'b1;
        #640 sda_low = 1'b0;
        #1400;
    endtask : stop_cond

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, ack);
    endtask : wr_byte

    // Last byte left without acknowledge
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(last, s);
    endtask : rd_byte
endmodule : rsp_bus_master

// ### verification/rtc_serial_slave_port_tb.sv
// Self-checking bench of the serial slave port
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((exp) !== (got)) begin error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module rtc_serial_slave_port_tb;
    logic sys_clk, link_clk, srst, pf, stall, reg_wr_ready;
    logic scl, sda_low, sda, sda_out, sda_oe, reg_wr, reg_rd, clock_freeze;
    logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rdata;
    logic [15:0] exp_q[$];
    logic [15:0] exp_w;
    int error_cnt = 0;
    int checks = 0;

    // Open-drain wire with pull-up
    assign sda = ~(sda_low | (sda_oe & ~sda_out));

    rsp_bus_master u_master (.sda(sda), .scl(scl), .sda_low(sda_low));

    rsp_slave_port u_dut (
        .sys_clk(sys_clk), .srst(srst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .below_battery_switchover_level(pf),
        .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
        .reg_wr_ready(reg_wr_ready), .reg_rd(reg_rd), .reg_rd_addr(reg_rd_addr),
        .reg_rdata(reg_rdata), .clock_freeze(clock_freeze)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end

    function automatic logic [7:0] reg_val(input logic [7:0] a);
        return a ^ 8'h5A;
    endfunction : reg_val

    // Register bank: read answer and randomly stalled write acceptance
    always @(posedge sys_clk) begin
        if (reg_rd === 1'b1) begin
            reg_rdata <= reg_val(reg_rd_addr);
        end
        reg_wr_ready <= (stall == 1'b0) && ($urandom_range(0, 3) != 0);
    end

    // Each register write is matched against the oldest note
    always @(posedge sys_clk) begin
        if (reg_wr === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("unexpected write", 1'b0, 1'b1)
            end else begin
                exp_w = exp_q.pop_front();
                `CHK("write addr and data", exp_w, {reg_wr_addr, reg_wr_data})
            end
        end
    end

    task automatic end_sim();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // Power fail is raised before byte number cut (data bytes from 0)
    task automatic write_seq(input logic [7:0] ptr, input int n, input int cut);
        logic a;
        logic [7:0] d;
        logic [7:0] p;
        p = ptr;
        u_master.start_cond();
        for (int i = -2; i < n; i++) begin
            if (i == cut) begin
                @(posedge sys_clk);
                pf <= 1'b1;
                repeat (40) @(posedge sys_clk);
            end
            d = (i == -2) ? {rsp_pkg::SLAVE_ADDR, 1'b0} : (i == -1) ? ptr : 8'($urandom());
            // Noted before sending: the write may appear before the ack clock ends
            if (i >= 0 && pf !== 1'b1) begin
                exp_q.push_back({p, d});
                p = (p == rsp_pkg::PTR_LAST) ? rsp_pkg::PTR_RESET : p + 8'h01;
            end
            u_master.wr_byte(d, a);
            `CHK("ack level", (pf === 1'b1), a)
        end
        u_master.stop_cond();
        @(posedge sys_clk);
        pf <= 1'b0;
        repeat (200) @(posedge sys_clk);
    endtask : write_seq

    task automatic read_seq(input logic [7:0] ptr, input logic set_ptr, input int n);
        logic a;
        logic [7:0] d;
        logic [7:0] p;
        p = ptr;
        u_master.start_cond();
        if (set_ptr) begin
            u_master.wr_byte({rsp_pkg::SLAVE_ADDR, 1'b0}, a);
            u_master.wr_byte(ptr, a);
            `CHK("pointer ack", 1'b0, a)
            #1000;
            `CHK("freeze in transfer", (ptr <= rsp_pkg::CLOCK_LAST), clock_freeze)
            u_master.start_cond();
        end
        u_master.wr_byte({rsp_pkg::SLAVE_ADDR, 1'b1}, a);
        `CHK("read address ack", 1'b0, a)
        for (int i = 0; i < n; i++) begin
            u_master.rd_byte(i == n - 1, d);
            `CHK("read data", reg_val(p), d)
            p = (p == rsp_pkg::PTR_LAST) ? rsp_pkg::PTR_RESET : p + 8'h01;
        end
        `CHK("released after nack", 1'b0, sda_oe)
        u_master.stop_cond();
        #1000;
        `CHK("freeze after stop", 1'b0, clock_freeze)
    endtask : read_seq

    initial begin
        logic a;
        logic [7:0] d;
        srst = 1'b1;
        pf = 1'b0;
        stall = 1'b0;
        void'($urandom(92415));
        // Reset must span several link clock edges too
        repeat (44) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (100) @(posedge sys_clk);
        write_seq(8'h12, 3, -99);
        d = 8'($urandom());
        if (d[7:1] == rsp_pkg::SLAVE_ADDR) begin
            d[7:1] = ~d[7:1];
        end
        u_master.start_cond();
        u_master.wr_byte(d, a);
        `CHK("foreign address ack", 1'b1, a)
        u_master.stop_cond();
        read_seq(8'h06, 1'b1, 3);
        read_seq(8'h09, 1'b0, 2);
        @(posedge sys_clk);
        stall <= 1'b1;
        write_seq(8'h00, 8, -99);
        `CHK("buffered writes", 8, exp_q.size())
        stall <= 1'b0;
        repeat (200) @(posedge sys_clk);
        `CHK("buffer drained", 0, exp_q.size())
        write_seq(8'h03, 2, 0);
        read_seq(8'h00, 1'b0, 1);
        `CHK("writes outstanding", 0, exp_q.size())
        end_sim();
    end

    initial begin
        #760000;
        error_cnt++;
        end_sim();
    end
endmodule : rtc_serial_slave_port_tb
